// file: fwdl_checker.sv
// Assertion checker on the ports of the download command handler
`default_nettype none
module fwdl_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_dma_data,
  input wire logic i_dma_valid,
  input wire logic o_avs_waitrequest,
  input wire logic o_dma_ready,
  input wire logic o_image_we,
  input wire logic [31:0] o_image_data,
  input wire logic [23:0] o_image_addr,
  input wire logic o_save_pulse,
  input wire logic o_spin_down
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ====================
  // Register bus answers
  a_ack_single: assert property (
    $fell(o_avs_waitrequest) |=> o_avs_waitrequest) else $error("ack held too long");
  a_ack_bounded: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest)
    else $error("request not answered");
  // ====================
  // Image words follow accepted beats
  a_word_cause: assert property (
    o_image_we |-> $past(i_dma_valid && o_dma_ready)) else $error("word without beat");
  a_word_copy: assert property (
    i_dma_valid && o_dma_ready |=> o_image_we && o_image_data == $past(i_dma_data))
    else $error("beat not stored");
  a_addr_step: assert property (
    o_image_we && $past(o_image_we) |-> o_image_addr == $past(o_image_addr) + 24'h1)
    else $error("image address skipped");
  // ====================
  // Save and spin-down outputs
  a_save_pulse: assert property (
    o_save_pulse |=> !o_save_pulse) else $error("save pulse too long");
  a_save_after: assert property (
    o_save_pulse |-> !o_dma_ready) else $error("save during transfer");
  a_spin_hold: assert property (
    o_spin_down |=> o_spin_down) else $error("spin down dropped");
  c_save: cover property (o_save_pulse);
  c_spin: cover property ($rose(o_spin_down));
  c_word: cover property (o_image_we);
endmodule
bind fwdl_core fwdl_checker u_fwdl_checker (.i_clk, .i_nrst, .i_avs_read, .i_avs_write,
  .i_dma_data, .i_dma_valid, .o_avs_waitrequest, .o_dma_ready, .o_image_we, .o_image_data,
  .o_image_addr, .o_save_pulse, .o_spin_down);
`default_nettype wire

// file: fwdl_core.v
// Firmware download by DMA command handler with Avalon-MM registers
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`include "fwdl_defs.vh"
`default_nettype none
module fwdl_core (
  input wire i_clk,
  input wire i_nrst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire [31:0] i_dma_data,
  input wire i_dma_valid,
  output reg o_dma_ready,
  input wire i_verify_ok,
  input wire i_reload_req,
  input wire i_reload_fail,
  output reg o_save_pulse,
  output reg o_activate_pulse,
  output reg o_spin_down,
  output reg [31:0] o_image_data,
  output reg [23:0] o_image_addr,
  output reg o_image_we,
  output reg o_irq
);
  // ==========================================================
  // State encoding
  localparam ST_IDLE = 2'd0;
  localparam ST_XFER = 2'd1;
  localparam ST_FIN = 2'd2;

  // Sequencer state and the task-file bytes written by software
  reg [1:0] state_q;
  reg [7:0] sub_q;
  reg [7:0] cntl_q;
  reg [7:0] cnth_q;
  reg [7:0] segl_q;
  reg [7:0] segh_q;
  reg [7:0] drv_q;
  // Result bytes read back by software
  reg [7:0] err_q;
  reg [7:0] stat_q;
  // Local control and interrupt registers
  reg [3:0] ctrl_q;
  reg [2:0] irq_st_q;
  reg [2:0] irq_msk_q;
  // Segment bookkeeping kept across commands
  reg [15:0] exp_off_q;
  reg in_progress_q;
  reg last_q;
  // Bus answer and image write pointer
  reg bus_ack_q;
  reg [23:0] wr_addr_q;
  // Word counter load path and its results
  reg hold_load;
  reg [23:0] hold_value;
  wire [23:0] words_left;
  wire words_zero;
  // Decoded fields and strobes
  wire [15:0] blk_count;
  wire [15:0] seg_off;
  wire wr_acc;
  wire rd_acc;
  wire cmd_wr;
  wire opc_dma;
  wire sub_legal;
  wire sub_offs;
  wire cmd_dma;
  wire cmd_foreign;
  wire word_take;
  // One-cycle event strobes into the interrupt status
  reg [2:0] irq_set;

  // ==========================================================
  // Bus decode
  // An access counts once, on the edge where no answer is pending
  assign wr_acc = i_avs_write && !bus_ack_q;
  assign rd_acc = i_avs_read && !bus_ack_q;
  assign cmd_wr = wr_acc && i_avs_address == `FWDL_OFF_CMD && i_avs_byteenable[0];
  // Opcode and subcommand decode
  assign opc_dma = i_avs_writedata[7:0] == `FWDL_OPC_DMA;
  assign sub_offs = sub_q == `FWDL_SUB_OFFS;
  assign sub_legal = sub_offs || sub_q == `FWDL_SUB_FULL;
  // A download command is taken only while idle; other opcodes are foreign
  assign cmd_dma = cmd_wr && opc_dma && state_q == ST_IDLE;
  assign cmd_foreign = cmd_wr && !opc_dma;
  assign blk_count = {cnth_q, cntl_q};
  assign seg_off = {segh_q, segl_q};
  // One image word moves on each stream handshake of the data phase
  assign word_take = state_q == ST_XFER && i_dma_valid && o_dma_ready;

  // Word counter of the running transfer
  fwdl_hold u_hold (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(hold_load),
    .i_value(hold_value),
    .i_dec(word_take),
    .o_count(words_left),
    .o_zero(words_zero)
  );

  // Word count of the block count, loaded only by an accepted command
  always @* begin
    hold_load = cmd_dma;
    // Each block is one 512-byte sector of 128 stream words
    hold_value = {1'b0, blk_count, 7'h00};
  end

  // ==========================================================
  // Bus slave: one wait cycle, then answer
  // A request counts on the first edge it is seen; the answer stands one cycle
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_ack_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      bus_ack_q <= (i_avs_read || i_avs_write) && !bus_ack_q;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !bus_ack_q);
      // Read mux; every byte register sits in the low byte lane
      if (rd_acc) begin
        case (i_avs_address)
          `FWDL_OFF_CNTL: o_avs_readdata <= {24'h000000, cntl_q};
          `FWDL_OFF_CNTH: o_avs_readdata <= {24'h000000, cnth_q};
          `FWDL_OFF_SEGL: o_avs_readdata <= {24'h000000, segl_q};
          `FWDL_OFF_SEGH: o_avs_readdata <= {24'h000000, segh_q};
          `FWDL_OFF_DRV: o_avs_readdata <= {24'h000000, drv_q};
          `FWDL_OFF_ERR: o_avs_readdata <= {24'h000000, err_q};
          `FWDL_OFF_STAT: o_avs_readdata <= {24'h000000, stat_q};
          `FWDL_OFF_CTRL: o_avs_readdata <= {28'h0000000, ctrl_q};
          `FWDL_OFF_IRQST: o_avs_readdata <= {29'h00000000, irq_st_q};
          `FWDL_OFF_IRQMSK: o_avs_readdata <= {29'h00000000, irq_msk_q};
          `FWDL_OFF_EXPOFF: o_avs_readdata <= {16'h0000, exp_off_q};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end else begin
        o_avs_readdata <= 32'h00000000;
      end
    end
  end

  // Task-file and control registers written by software
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_q <= 8'h00;
      cntl_q <= 8'h00;
      cnth_q <= 8'h00;
      segl_q <= 8'h00;
      segh_q <= 8'h00;
      drv_q <= 8'h00;
      ctrl_q <= 4'h0;
      irq_msk_q <= 3'h0;
    end else begin
      // Soft reset bit clears itself one cycle after it is written
      ctrl_q[`FWDL_CTL_SWRST] <= 1'b0;
      // Only the low byte lane carries register data
      if (wr_acc && i_avs_byteenable[0]) begin
        case (i_avs_address)
          `FWDL_OFF_SUB: sub_q <= i_avs_writedata[7:0];
          `FWDL_OFF_CNTL: cntl_q <= i_avs_writedata[7:0];
          `FWDL_OFF_CNTH: cnth_q <= i_avs_writedata[7:0];
          `FWDL_OFF_SEGL: segl_q <= i_avs_writedata[7:0];
          `FWDL_OFF_SEGH: segh_q <= i_avs_writedata[7:0];
          `FWDL_OFF_DRV: drv_q <= i_avs_writedata[7:0];
          `FWDL_OFF_CTRL: ctrl_q <= i_avs_writedata[3:0];
          `FWDL_OFF_IRQMSK: irq_msk_q <= i_avs_writedata[2:0];
          default: ctrl_q[`FWDL_CTL_SWRST] <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Command sequencing and segment tracking
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      err_q <= 8'h00;
      stat_q <= `FWDL_STAT_RST;
      exp_off_q <= 16'h0000;
      in_progress_q <= 1'b0;
      last_q <= 1'b0;
      wr_addr_q <= 24'h000000;
      o_dma_ready <= 1'b0;
      o_save_pulse <= 1'b0;
      o_activate_pulse <= 1'b0;
      o_spin_down <= 1'b0;
      o_image_data <= 32'h00000000;
      o_image_addr <= 24'h000000;
      o_image_we <= 1'b0;
      irq_set <= 3'h0;
    end else begin
      o_save_pulse <= 1'b0;
      o_activate_pulse <= 1'b0;
      o_image_we <= 1'b0;
      irq_set <= 3'h0;
      if (ctrl_q[`FWDL_CTL_SWRST]) begin
        // Software reset drops partial image first
        in_progress_q <= 1'b0;
        exp_off_q <= 16'h0000;
        state_q <= ST_IDLE;
        o_dma_ready <= 1'b0;
        err_q <= 8'h00;
        stat_q <= `FWDL_STAT_RST;
      end else if (cmd_dma) begin
        // Accepted command: clear the result bytes and raise busy
        err_q <= 8'h00;
        stat_q <= 8'h00;
        stat_q[`FWDL_ST_BSY] <= 1'b1;
        // Mode 07h is always final; mode 03h is final when software marks it
        last_q <= ctrl_q[`FWDL_CTL_LAST] || sub_q == `FWDL_SUB_FULL;
        // Reserved subcommand or a locked drive aborts at once
        if (!sub_legal || ctrl_q[`FWDL_CTL_LOCK]) begin
          err_q[`FWDL_ERR_ABT] <= 1'b1;
          state_q <= ST_FIN;
        end else if (sub_offs && in_progress_q && seg_off != exp_off_q) begin
          // Segment out of sequence: drop everything received so far
          err_q[`FWDL_ERR_ABT] <= 1'b1;
          in_progress_q <= 1'b0;
          exp_off_q <= 16'h0000;
          state_q <= ST_FIN;
        end else if (sub_offs && !in_progress_q && seg_off != 16'h0000) begin
          // The first segment of an offset download must start at zero
          err_q[`FWDL_ERR_ABT] <= 1'b1;
          state_q <= ST_FIN;
        end else begin
          // Segment placed at its 512-byte offset (128 words)
          wr_addr_q <= sub_offs ? {1'b0, seg_off, 7'h00} : 24'h000000;
          in_progress_q <= sub_offs;
          exp_off_q <= sub_offs ? seg_off + blk_count : 16'h0000;
          // A zero count finishes at once with no data phase
          if (blk_count == 16'h0000) begin
            state_q <= ST_FIN;
          end else begin
            stat_q[`FWDL_ST_DRQ] <= 1'b1;
            o_dma_ready <= 1'b1;
            state_q <= ST_XFER;
          end
        end
      end else begin
        case (state_q)
          ST_XFER: begin
            // Each accepted word reaches the image port one cycle later
            if (word_take) begin
              o_image_data <= i_dma_data;
              o_image_addr <= wr_addr_q;
              o_image_we <= 1'b1;
              wr_addr_q <= wr_addr_q + 24'h000001;
            end
            // Leave after the last word, or at once if the counter is empty
            if ((word_take && words_left == 24'h000001) || words_zero) begin
              o_dma_ready <= 1'b0;
              state_q <= ST_FIN;
            end
          end
          ST_FIN: begin
            // Only a clean final segment is verified, saved and made live
            if (last_q && !err_q[`FWDL_ERR_ABT]) begin
              in_progress_q <= 1'b0;
              exp_off_q <= 16'h0000;
              if (i_verify_ok) begin
                o_save_pulse <= 1'b1;
                o_activate_pulse <= 1'b1;
                irq_set[`FWDL_IRQ_SAVED] <= 1'b1;
                // Spin down in the same cycle as the activation pulse when spin-up is disabled
                if (ctrl_q[`FWDL_CTL_SPINDIS]) begin
                  o_spin_down <= 1'b1;
                end
              end else begin
                // Failed verification aborts and keeps the old firmware
                err_q[`FWDL_ERR_ABT] <= 1'b1;
              end
              // Reload failure is reported only when a reload was asked for
              if (i_reload_req && i_reload_fail) begin
                err_q[`FWDL_ERR_UNC] <= 1'b1;
              end
            end
            // Completion: ready, not busy, error from flags
            stat_q[`FWDL_ST_BSY] <= 1'b0;
            stat_q[`FWDL_ST_DRQ] <= 1'b0;
            stat_q[`FWDL_ST_RDY] <= 1'b1;
            stat_q[`FWDL_ST_DSC] <= 1'b1;
            stat_q[`FWDL_ST_ERR] <= err_q[`FWDL_ERR_ABT] || err_q[`FWDL_ERR_UNC]
                                    || (last_q && !i_verify_ok)
                                    || (last_q && i_reload_req && i_reload_fail);
            irq_set[`FWDL_IRQ_DONE] <= 1'b1;
            irq_set[`FWDL_IRQ_ABORT] <= err_q[`FWDL_ERR_ABT]
                                        || (last_q && !i_verify_ok);
            state_q <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      // A foreign command runs on its own handler; here it only drops the
      // partial image, so a stream word taken in that cycle is still kept
      if (cmd_foreign) begin
        in_progress_q <= 1'b0;
        exp_off_q <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Sticky interrupt status, write one to clear, set wins
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_st_q <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      if (wr_acc && i_avs_address == `FWDL_OFF_IRQST && i_avs_byteenable[0]) begin
        irq_st_q <= (irq_st_q & ~i_avs_writedata[2:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      // Interrupt line follows the unmasked status one cycle later
      o_irq <= |(irq_st_q & irq_msk_q);
    end
  end
endmodule
`default_nettype wire

// file: fwdl_defs.vh
// Constants for the firmware download by DMA command handler
`ifndef FWDL_DEFS_VH
`define FWDL_DEFS_VH
// Register word offsets (word addresses)
`define FWDL_OFF_CMD 4'h0
`define FWDL_OFF_SUB 4'h1
`define FWDL_OFF_CNTL 4'h2
`define FWDL_OFF_CNTH 4'h3
`define FWDL_OFF_SEGL 4'h4
`define FWDL_OFF_SEGH 4'h5
`define FWDL_OFF_DRV 4'h6
`define FWDL_OFF_ERR 4'h7
`define FWDL_OFF_STAT 4'h8
`define FWDL_OFF_CTRL 4'h9
`define FWDL_OFF_IRQST 4'ha
`define FWDL_OFF_IRQMSK 4'hb
`define FWDL_OFF_EXPOFF 4'hc
// Opcodes and subcommands
`define FWDL_OPC_DMA 8'h93
`define FWDL_SUB_OFFS 8'h03
`define FWDL_SUB_FULL 8'h07
// Error register bits
`define FWDL_ERR_ABT 2
`define FWDL_ERR_UNC 6
// Status register bits
`define FWDL_ST_BSY 7
`define FWDL_ST_RDY 6
`define FWDL_ST_DSC 4
`define FWDL_ST_DRQ 3
`define FWDL_ST_ERR 0
// Control register bits
`define FWDL_CTL_LOCK 0
`define FWDL_CTL_SPINDIS 1
`define FWDL_CTL_SWRST 2
`define FWDL_CTL_LAST 3
// Interrupt status bits
`define FWDL_IRQ_DONE 0
`define FWDL_IRQ_ABORT 1
`define FWDL_IRQ_SAVED 2
`define FWDL_IRQ_W 3
// Reset values
`define FWDL_STAT_RST 8'h50
// Sector size in words of the data stream (32-bit words)
`define FWDL_SECT_WORDS 8'd128
`endif

// file: fwdl_hold.v
// Countdown of words left in a sector run
`default_nettype none
module fwdl_hold (
  input wire i_clk,
  input wire i_nrst,
  input wire i_load,
  input wire [23:0] i_value,
  input wire i_dec,
  output reg [23:0] o_count,
  output wire o_zero
);
  // Loads a count and steps it down per accepted word
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= 24'h000000;
    end else if (i_load) begin
      o_count <= i_value;
    end else if (i_dec && o_count != 24'h000000) begin
      o_count <= o_count - 24'h000001;
    end
  end
  assign o_zero = (o_count == 24'h000000);
endmodule
`default_nettype wire

// file: fwdl_host_model.sv
// Host DMA source streaming numbered image words
`default_nettype none
module fwdl_host_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [23:0] i_base,
  input wire logic [23:0] i_words,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] left_q = 24'h0;
  logic [23:0] addr_q = 24'h0;
  logic [1:0] ph_q = 2'h0;
  logic valid_q = 1'b0;
  logic [23:0] left_d;
  assign left_d = left_q - {23'h0, valid_q && i_ready};
  // Word held until taken; released bus shows inverted data
  assign o_valid = valid_q;
  assign o_data = valid_q ? {8'h5a, addr_q} : ~{8'h5a, addr_q};
  // Any count of i_words words, stalls every fourth cycle when slow
  always @(posedge i_clk) begin
    ph_q <= ph_q + 2'h1;
    if (i_start) begin
      left_q <= i_words;
      addr_q <= i_base;
      valid_q <= 1'b0;
    end else begin
      left_q <= left_d;
      if (valid_q && i_ready)
        addr_q <= addr_q + 24'h1;
      if (!valid_q || i_ready)
        valid_q <= left_d != 24'h0 && !(i_slow && ph_q == 2'h0);
    end
  end
endmodule
`default_nettype wire

// file: test_firmware_download_dma_cmd.sv
// Self-checking bench for the firmware download command handler
`default_nettype none
module test_firmware_download_dma_cmd;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_nrst = 0, rd = 0, wr = 0, wreq, dvalid, dready, save, act, spin, iwe, irq;
  logic vok = 1, rreq = 0, rfail = 0, hstart = 0, slow = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 0, rdat, ddata, idata, got;
  logic [23:0] hbase = 0, hwords = 0, iaddr;
  int fails = 0, check_count = 0, cyc = 0, nwe = 0, nsave = 0, nact = 0;
  fwdl_core u_fwdl_core (.i_clk, .i_nrst, .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_dma_data(ddata), .i_dma_valid(dvalid), .o_dma_ready(dready),
    .i_verify_ok(vok), .i_reload_req(rreq), .i_reload_fail(rfail), .o_save_pulse(save),
    .o_activate_pulse(act), .o_spin_down(spin), .o_image_data(idata), .o_image_addr(iaddr),
    .o_image_we(iwe), .o_irq(irq));
  fwdl_host_model u_fwdl_host_model (.i_clk, .i_start(hstart), .i_slow(slow), .i_base(hbase),
    .i_words(hwords), .i_ready(dready), .o_valid(dvalid), .o_data(ddata));
  // Clock
  initial forever #12.5 i_clk = ~i_clk;
  // ====================
  // Image port watch and run limit
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (iwe) begin
      nwe <= nwe + 1;
      chk("image word", {8'h5a, iaddr}, idata);
    end
    if (save)
      nsave <= nsave + 1;
    if (act)
      nact <= nact + 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ====================
  // Bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge i_clk);
    while (wreq === 1'b1)
      @(posedge i_clk);
    got = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, e, got);
  endtask
  task automatic outcome(input logic [7:0] e);
    rdc(4'h7, {24'h0, e}, "error reg");
    rdc(4'h8, {24'h0, 7'h28, e != 8'h00}, "status");
  endtask
  // Task-file setup, command, stream, then wait for not busy
  task automatic run(input logic [7:0] sub, input logic [15:0] cnt, input logic [15:0] off,
                     input logic [7:0] ctl, input logic ok);
    nwe = 0;
    nsave = 0;
    nact = 0;
    bus(1, 4'h1, sub);
    bus(1, 4'h2, cnt[7:0]);
    bus(1, 4'h3, cnt[15:8]);
    bus(1, 4'h4, off[7:0]);
    bus(1, 4'h5, off[15:8]);
    bus(1, 4'h9, ctl);
    hbase <= {1'b0, off, 7'h0};
    hwords <= ok ? {1'b0, cnt, 7'h0} : 24'h0;
    bus(1, 4'h0, 8'h93);
    hstart <= 1;
    @(posedge i_clk);
    hstart <= 0;
    got = 32'h80;
    while (got[7] === 1'b1)
      bus(0, 4'h8, 0);
  endtask
  // ====================
  // Scenarios
  task automatic t_full();
    bus(1, 4'hb, 1);
    run(8'h07, 16'h0100, 16'h0, 8'h0, 1);
    chk("words", 32768, nwe);
    chk("saves", 1, nsave);
    chk("activations", 1, nact);
    outcome(8'h00);
    chk("irq on", 1, irq);
    bus(1, 4'ha, 1);
    repeat (2) @(posedge i_clk);
    chk("irq off", 0, irq);
    rdc(4'hd, 0, "unmapped");
    bus(1, 4'h6, 8'ha5);
    rdc(4'h6, 8'ha5, "drive select");
  endtask
  task automatic t_bad();
    logic [7:0] subs[3] = '{8'h00, 8'h05, 8'hff};
    foreach (subs[i]) begin
      run(subs[i], 16'h1, 16'h0, 8'h0, 0);
      outcome(8'h04);
    end
    run(8'h07, 16'h1, 16'h0, 8'h01, 0);
    outcome(8'h04);
    run(8'h07, 16'h0, 16'h0, 8'h0, 1);
    chk("zero words", 0, nwe);
  endtask
  task automatic t_seg();
    slow <= 1;
    run(8'h03, 16'h1, 16'h0, 8'h0, 1);
    chk("early save", 0, nsave);
    rdc(4'hc, 1, "next offset");
    run(8'h03, 16'h2, 16'h1, 8'h08, 1);
    chk("seg words", 256, nwe);
    chk("seg save", 1, nsave);
    outcome(8'h00);
    slow <= 0;
    run(8'h03, 16'h1, 16'h0, 8'h0, 1);
    run(8'h03, 16'h1, 16'h5, 8'h0, 0);
    outcome(8'h04);
    rdc(4'hc, 0, "offset cleared");
  endtask
  task automatic t_drop();
    run(8'h03, 16'h1, 16'h0, 8'h0, 1);
    bus(1, 4'h0, 8'hec);
    repeat (4) @(posedge i_clk);
    run(8'h03, 16'h1, 16'h1, 8'h08, 0);
    outcome(8'h04);
    run(8'h03, 16'h1, 16'h0, 8'h0, 1);
    bus(1, 4'h9, 8'h04);
    run(8'h03, 16'h1, 16'h1, 8'h08, 0);
    outcome(8'h04);
    run(8'h03, 16'h1, 16'h0, 8'h0, 1);
    i_nrst <= 0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1;
    run(8'h03, 16'h1, 16'h1, 8'h08, 0);
    outcome(8'h04);
  endtask
  task automatic t_reload();
    rreq <= 1;
    rfail <= 1;
    run(8'h07, 16'h1, 16'h0, 8'h02, 1);
    outcome(8'h40);
    chk("spin down", 1, spin);
    rreq <= 0;
    run(8'h07, 16'h1, 16'h0, 8'h00, 1);
    outcome(8'h00);
    rfail <= 0;
    vok <= 0;
    run(8'h07, 16'h1, 16'h0, 8'h00, 1);
    chk("verify save", 0, nsave);
    outcome(8'h04);
    vok <= 1;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1;
    rdc(4'h8, 32'h50, "status reset");
    t_full();
    t_bad();
    t_seg();
    t_drop();
    t_reload();
    end_of_test();
  end
endmodule
`default_nettype wire
